//--- shared/rc_pkg.sv
//==============================================================
// Purpose : shared constants for the remote code encoder/decoder
// Assumes : 40 MHz clk, one clock domain
// Notes   : trit codes are two line bits, sent first bit first
//==============================================================
package rc_pkg;
    localparam int CLK_MHZ     = 40;
    localparam int BIT_TIME_NS = 10000;
    typedef logic [11:0] cnt_t;

    // bit cell: a one is high for three quarters, a zero for one quarter
    localparam cnt_t BIT_CYC          = cnt_t'((BIT_TIME_NS * CLK_MHZ) / 1000);
    localparam cnt_t ONE_HIGH_CYC     = cnt_t'((BIT_TIME_NS * CLK_MHZ * 3) / 4000);
    localparam cnt_t ZERO_HIGH_CYC    = cnt_t'((BIT_TIME_NS * CLK_MHZ) / 4000);
    localparam cnt_t BIT_THRESH_CYC   = cnt_t'((BIT_TIME_NS * CLK_MHZ) / 2000);
    localparam cnt_t WORD_END_CYC     = cnt_t'((BIT_TIME_NS * CLK_MHZ * 2) / 1000);
    localparam cnt_t ENC_GAP_CYC      = cnt_t'((BIT_TIME_NS * CLK_MHZ * 3) / 1000);
    localparam cnt_t SEQ_GAP_CYC      = cnt_t'((BIT_TIME_NS * CLK_MHZ * 4) / 1000);
    localparam cnt_t PROBE_SETTLE_CYC = cnt_t'(4);

    localparam int NUM_LINES  = 9;
    localparam int NUM_DATA   = 4;
    localparam int WORD_BITS  = 18;
    localparam logic [4:0] WORD_BITS_CNT = 5'h12;
    localparam logic [4:0] LAST_BIT_IDX  = 5'h11;

    typedef logic [1:0] trit_t;
    localparam trit_t TRIT_LOW  = 2'h0;
    localparam trit_t TRIT_OPEN = 2'h2;
    localparam trit_t TRIT_HIGH = 2'h3;

    localparam logic [3:0] DATA_RST = 4'h0;
endpackage

//--- core/rc_encoder.sv
//==============================================================
// Purpose : encoder, probes nine lines and sends the word twice
// Assumes : line_sync already passed two flip-flops
// Notes   : open lines are found by driving high then low
//==============================================================
module rc_encoder (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    input  wire logic       trig,
    input  wire logic [8:0] line_sync,
    output logic      [8:0] line_out,
    output logic      [8:0] line_oe,
    output logic            serial_out
);
    typedef enum logic [2:0] {ENC_IDLE, ENC_PROBE_HI, ENC_PROBE_LO, ENC_SEND, ENC_GAP} enc_state_e;

    enc_state_e    state_q, state_d;
    rc_pkg::cnt_t  cnt_q, cnt_d;
    logic [4:0]    bit_q;
    logic          word_q;
    logic [8:0]    samp_hi_q;
    logic [17:0]   shift_q;
    logic [17:0]   word_new;
    logic [8:0]    line_out_q, line_oe_q;
    logic          serial_q;

    wire           settled  = (cnt_q == rc_pkg::PROBE_SETTLE_CYC);
    wire           bit_end  = (cnt_q == rc_pkg::BIT_CYC - 12'h001);
    wire           gap_end  = (cnt_q == rc_pkg::ENC_GAP_CYC - 12'h001);
    wire           last_bit = (bit_q == rc_pkg::LAST_BIT_IDX);
    wire rc_pkg::cnt_t hi_len = shift_q[17] ? rc_pkg::ONE_HIGH_CYC : rc_pkg::ZERO_HIGH_CYC;

    // a tied line reads the same in both phases; an open one follows the drive
    for (genvar i = 0; i < rc_pkg::NUM_LINES; i++) begin : g_trit
        assign word_new[17-2*i -: 2] = {samp_hi_q[i] | line_sync[i],
                                        samp_hi_q[i] & line_sync[i]};
    end

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q + 12'h001;
        case (state_q)
            ENC_IDLE: begin
                cnt_d = '0;
                if (trig) state_d = ENC_PROBE_HI;
            end
            ENC_PROBE_HI: if (settled) begin
                state_d = ENC_PROBE_LO;
                cnt_d   = '0;
            end
            ENC_PROBE_LO: if (settled) begin
                state_d = ENC_SEND;
                cnt_d   = '0;
            end
            ENC_SEND: if (bit_end) begin
                cnt_d = '0;
                if (last_bit) state_d = ENC_GAP;
            end
            ENC_GAP: if (gap_end) begin
                cnt_d   = '0;
                state_d = word_q ? ENC_IDLE : ENC_SEND;
            end
            default: begin
                state_d = ENC_IDLE;
                cnt_d   = '0;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_q    <= ENC_IDLE;
            cnt_q      <= '0;
            bit_q      <= '0;
            word_q     <= 1'b0;
            samp_hi_q  <= '0;
            shift_q    <= '0;
            line_out_q <= '0;
            line_oe_q  <= '0;
            serial_q   <= 1'b0;
        end else if (ce) begin
            state_q    <= state_d;
            cnt_q      <= cnt_d;
            line_oe_q  <= {9{state_d == ENC_PROBE_HI || state_d == ENC_PROBE_LO}};
            line_out_q <= {9{state_d == ENC_PROBE_HI}};
            serial_q   <= (state_q == ENC_SEND) && (cnt_q < hi_len);
            if (state_q == ENC_PROBE_HI && settled) samp_hi_q <= line_sync;
            if (state_q == ENC_PROBE_LO && settled) begin
                shift_q <= word_new;
                bit_q   <= '0;
                word_q  <= 1'b0;
            end
            // rotation brings the same word back for the repeat
            if (state_q == ENC_SEND && bit_end) begin
                shift_q <= {shift_q[16:0], shift_q[17]};
                bit_q   <= last_bit ? 5'h00 : bit_q + 5'h01;
            end
            if (state_q == ENC_GAP && gap_end) word_q <= ~word_q;
        end
    end

    assign line_out   = line_out_q;
    assign line_oe    = line_oe_q;
    assign serial_out = serial_q;

    chk_trig_start: assert property (@(posedge clk) disable iff (rst)
        (ce && state_q == ENC_IDLE && trig) |=> state_q == ENC_PROBE_HI)
        else $error("trigger did not start probing");
    chk_probe_release: assert property (@(posedge clk) disable iff (rst)
        (state_q == ENC_SEND) |-> line_oe_q == 9'h000)
        else $error("lines still driven while sending");
    chk_two_words: assert property (@(posedge clk) disable iff (rst)
        (ce && state_q == ENC_GAP && gap_end) |=> (state_q == ENC_IDLE) == $past(word_q))
        else $error("sequence did not end after the second word");
    chk_bit_cell: assert property (@(posedge clk) disable iff (rst)
        (ce && state_q == ENC_SEND && cnt_q == 12'h000) |=> serial_q ##1 serial_q)
        else $error("bit cell did not open high");
endmodule // rc_encoder

//--- core/remote_code_encoder_decoder.sv
//==============================================================
// Purpose : remote code encoder plus decoder, decoder variant by parameter
// Assumes : pins asynchronous to clk; ce high for normal running
// Notes   : ADDR_ONLY=0 gives 5 address + 4 data, 1 gives 9 address
//==============================================================
module remote_code_encoder_decoder #(
    parameter bit ADDR_ONLY = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        transmit_trigger,
    input  wire logic [8:0]  line_in,
    output logic      [8:0]  line_out,
    output logic      [8:0]  line_oe,
    output logic             serial_code_out,
    input  wire logic        serial_code_in,
    input  wire logic [17:0] local_addr,
    output logic             valid_reception_flag,
    output logic      [3:0]  decoded_data_output
);

    //==============================================================
    // input synchronisers
    //==============================================================
    logic        trig_s1, trig_s2;
    logic [8:0]  line_s1, line_s2;
    logic        rx_s1, rx_s2;
    logic [17:0] addr_s1, addr_s2;

    always_ff @(posedge clk) begin
        if (rst) begin
            trig_s1 <= 1'b0;
            trig_s2 <= 1'b0;
            line_s1 <= '0;
            line_s2 <= '0;
            rx_s1   <= 1'b0;
            rx_s2   <= 1'b0;
            addr_s1 <= '0;
            addr_s2 <= '0;
        end else if (ce) begin
            trig_s1 <= transmit_trigger;
            trig_s2 <= trig_s1;
            line_s1 <= line_in;
            line_s2 <= line_s1;
            rx_s1   <= serial_code_in;
            rx_s2   <= rx_s1;
            addr_s1 <= local_addr;
            addr_s2 <= addr_s1;
        end
    end

    //==============================================================
    // encoder
    //==============================================================
    rc_encoder u_encoder (
        .clk        (clk),
        .rst        (rst),
        .ce         (ce),
        .trig       (trig_s2),
        .line_sync  (line_s2),
        .line_out   (line_out),
        .line_oe    (line_oe),
        .serial_out (serial_code_out)
    );

    //==============================================================
    // decoder: pulse width to bits
    //==============================================================
    logic          rx_prev_q;
    rc_pkg::cnt_t  hi_cnt_q, lo_cnt_q;
    logic [4:0]    nbits_q;
    logic [17:0]   shift_q;

    wire rise      = rx_s2 & ~rx_prev_q;
    wire fall      = ~rx_s2 & rx_prev_q;
    wire bit_val   = (hi_cnt_q > rc_pkg::BIT_THRESH_CYC);
    wire word_end  = ~rx_s2 && (lo_cnt_q == rc_pkg::WORD_END_CYC);
    wire seq_end   = ~rx_s2 && (lo_cnt_q == rc_pkg::SEQ_GAP_CYC);
    wire word_done = word_end && (nbits_q == rc_pkg::WORD_BITS_CNT);

    always_ff @(posedge clk) begin
        if (rst) begin
            rx_prev_q <= 1'b0;
            hi_cnt_q  <= '0;
            lo_cnt_q  <= rc_pkg::SEQ_GAP_CYC;
            nbits_q   <= '0;
            shift_q   <= '0;
        end else if (ce) begin
            rx_prev_q <= rx_s2;
            if (rise)
                hi_cnt_q <= 12'h001;
            else if (rx_s2 && hi_cnt_q != 12'hFFF)
                hi_cnt_q <= hi_cnt_q + 12'h001;
            // low time saturates at the sequence gap, which then reads as idle
            if (rx_s2)
                lo_cnt_q <= '0;
            else if (lo_cnt_q != rc_pkg::SEQ_GAP_CYC)
                lo_cnt_q <= lo_cnt_q + 12'h001;
            if (fall) begin
                shift_q <= {shift_q[16:0], bit_val};
                if (nbits_q != 5'h1F) nbits_q <= nbits_q + 5'h01;
            end else if (word_end) begin
                nbits_q <= '0;
            end
        end
    end

    //==============================================================
    // decoder: address and data checks
    //==============================================================
    logic [3:0] rx_data;
    logic [3:0] data_bin;

    // data digits must be plain binary, an open digit spoils the word
    for (genvar j = 0; j < rc_pkg::NUM_DATA; j++) begin : g_data
        assign rx_data[j]  = shift_q[7-2*j];
        assign data_bin[j] = (shift_q[7-2*j] == shift_q[6-2*j]);
    end

    wire addr_match = ADDR_ONLY ? (shift_q == addr_s2)
                                : (shift_q[17:8] == addr_s2[17:8]);
    wire data_legal = ADDR_ONLY | (&data_bin);
    wire word_good  = addr_match & data_legal;

    logic       have_q;
    logic [3:0] prev_data_q;
    logic       accept_q;
    logic [3:0] data_q;
    logic       vt_q;

    wire data_same = ADDR_ONLY | (rx_data == prev_data_q);
    wire accept    = word_done & word_good & have_q & data_same;

    always_ff @(posedge clk) begin
        if (rst) begin
            have_q      <= 1'b0;
            prev_data_q <= rc_pkg::DATA_RST;
            accept_q    <= 1'b0;
            data_q      <= rc_pkg::DATA_RST;
            vt_q        <= 1'b0;
        end else if (ce) begin
            if (word_done) begin
                have_q      <= word_good;
                prev_data_q <= rx_data;
            end else if (seq_end) begin
                have_q <= 1'b0;
            end
            accept_q <= accept;
            // data lands one cycle ahead of the flag
            if (accept && !ADDR_ONLY) data_q <= rx_data;
            if (seq_end || (word_done && !word_good)) vt_q <= 1'b0;
            if (accept_q) vt_q <= 1'b1;
        end
    end

    assign valid_reception_flag = vt_q;
    assign decoded_data_output  = data_q;

    //==============================================================
    // checks
    //==============================================================
    chk_vt_cause: assert property (@(posedge clk) disable iff (rst)
        $rose(vt_q) |-> $past(accept_q))
        else $error("valid rose without an accepted pair");
    chk_accept_src: assert property (@(posedge clk) disable iff (rst)
        (ce && accept_q) |-> $past(word_done && addr_match && have_q && data_same))
        else $error("accept without matching address and data");
    chk_data_first: assert property (@(posedge clk) disable iff (rst)
        (ce && accept && !ADDR_ONLY) |=> (data_q == $past(rx_data)) ##1 vt_q)
        else $error("data not in place before valid");
    chk_fail_hold: assert property (@(posedge clk) disable iff (rst)
        (ce && word_done && !word_good) |=> $stable(data_q) && !vt_q)
        else $error("failed word changed data or kept valid");
    chk_reset_low: assert property (@(posedge clk) disable iff (rst)
        $fell(rst) |-> !vt_q && data_q == rc_pkg::DATA_RST && !serial_code_out)
        else $error("outputs not low after reset");
    chk_addr_only: assert property (@(posedge clk) disable iff (rst)
        ADDR_ONLY |-> data_q == rc_pkg::DATA_RST)
        else $error("address-only variant drove data");
endmodule // remote_code_encoder_decoder

//--- bench/rc_link.sv
// Purpose : far-side link model, relays the code and decodes what it sees
// Assumes : high longer than half a bit cell is a one
// Notes   : drop_second silences the carrier after the first word
module rc_link (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        clear,
    input  wire logic        drop_second,
    input  wire logic        tx_in,
    output logic             rx_out,
    output logic      [5:0]  bits_seen,
    output logic      [35:0] bits_q
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [11:0] high_len;
    logic        tx_q;
    // ==========================================================
    // bit capture on each falling edge
    always_ff @(posedge clk) begin
        tx_q <= tx_in;
        if (rst || clear) begin
            bits_seen <= 6'h00;
            high_len  <= 12'h000;
        end else begin
            high_len <= tx_in ? high_len + 12'h001 : 12'h000;
            if (tx_q && !tx_in) begin
                bits_seen <= bits_seen + 6'h01;
                bits_q    <= {bits_q[34:0], high_len > 12'h0C8};
            end
        end
    end
    // a silenced demodulator idles low, as with no carrier
    assign rx_out = (drop_second && bits_seen >= 6'h12) ? 1'b0 : tx_in;
endmodule // rc_link

//--- bench/remote_code_encoder_decoder_bench.sv
// Purpose : self-checking bench, encoder looped to both decoder variants
// Assumes : open lines read back what the encoder probes
// Notes   : about 75000 cycles per run
module remote_code_encoder_decoder_bench;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk = 1'b0, rst = 1'b1, trig = 1'b0, clear = 1'b0, drop = 1'b0;
    logic        noise = 1'b0, ser_tx, ser_rx, vld_s, vld_a;
    logic [8:0]  tie_lvl = 9'h000, tie_open = 9'h000, line_in, line_out, line_oe;
    logic [17:0] addr_s = 18'h00000, addr_a = 18'h00000;
    logic [3:0]  dat_s, dat_a, exp_dat = 4'h0;
    logic [5:0]  bits_seen;
    logic [35:0] bits_q;
    logic [31:0] rnd = 32'h15C7;
    int          n_errors = 0, checks_done = 0, cycles = 0;
    always #12.5 clk = ~clk;
    // an undriven open line wanders, so the encoder must sample only while probing
    assign line_in = (tie_open & ((line_oe & line_out) | (~line_oe & {9{noise}})))
                   | (~tie_open & tie_lvl);
    remote_code_encoder_decoder #(.ADDR_ONLY(1'b0)) i_remote_code_encoder_decoder (
        .clk(clk), .rst(rst), .ce(1'b1), .transmit_trigger(trig), .line_in(line_in),
        .line_out(line_out), .line_oe(line_oe), .serial_code_out(ser_tx),
        .serial_code_in(ser_rx), .local_addr(addr_s), .valid_reception_flag(vld_s),
        .decoded_data_output(dat_s));
    remote_code_encoder_decoder #(.ADDR_ONLY(1'b1)) i_remote_code_encoder_decoder_b (
        .clk(clk), .rst(rst), .ce(1'b1), .transmit_trigger(1'b0), .line_in(line_in),
        .line_out(), .line_oe(), .serial_code_out(), .serial_code_in(ser_rx),
        .local_addr(addr_a), .valid_reception_flag(vld_a), .decoded_data_output(dat_a));
    rc_link i_rc_link (.clk(clk), .rst(rst), .clear(clear), .drop_second(drop),
        .tx_in(ser_tx), .rx_out(ser_rx), .bits_seen(bits_seen), .bits_q(bits_q));
    // ==========================================================
    // helpers
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    function automatic logic [17:0] word_of(input logic [8:0] lv, input logic [8:0] op);
        logic [17:0] w;
        for (int i = 0; i < 9; i++)
            w[17-2*i -: 2] = op[i] ? rc_pkg::TRIT_OPEN
                                   : (lv[i] ? rc_pkg::TRIT_HIGH : rc_pkg::TRIT_LOW);
        return w;
    endfunction
    function automatic logic [1:0] other(input logic [1:0] c);
        return (c === rc_pkg::TRIT_LOW) ? rc_pkg::TRIT_HIGH : rc_pkg::TRIT_LOW;
    endfunction
    task automatic report_and_stop();
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic cmp(input string what, input logic [35:0] e, input logic [35:0] g);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask
    // data lines stay binary so the split decoder can accept them
    task automatic setup(input int ms, input int ma);
        logic [17:0] w;
        for (int i = 0; i < 9; i++) begin
            rnd = lfsr(rnd);
            tie_open[i] = (i < 5) && (rnd[1:0] == 2'h3);
            tie_lvl[i] = rnd[2];
        end
        tie_open[0] = (ms < 0);
        w = word_of(tie_lvl, tie_open);
        addr_s = {w[17:8], rnd[10:3]};
        addr_a = w;
        if (ms >= 0)
            addr_s[17-2*ms -: 2] = other(w[17-2*ms -: 2]);
        if (ma >= 0)
            addr_a[17-2*ma -: 2] = other(w[17-2*ma -: 2]);
    endtask
    task automatic run_seq(input string name, input logic d, input logic ok_s, input logic ok_a);
        logic [17:0] w;
        int          n;
        w = word_of(tie_lvl, tie_open);
        @(posedge clk);
        #1 drop = d;
        clear = 1'b1;
        trig = 1'b1;
        @(posedge clk);
        #1 clear = 1'b0;
        repeat (4) @(posedge clk);
        #1 trig = 1'b0;
        n = 0;
        while (bits_seen !== 6'h24 && n < 20000) begin
            @(posedge clk);
            n++;
        end
        repeat (900) @(posedge clk);
        #2;
        if (ok_s)
            exp_dat = tie_lvl[8:5];
        cmp("wire words", {w, w}, bits_q);
        cmp("split valid", 36'(ok_s), 36'(vld_s));
        cmp("split data", 36'(exp_dat), 36'(dat_s));
        cmp("addr only valid", 36'(ok_a), 36'(vld_a));
        cmp("addr only data", 36'h0, 36'(dat_a));
        cmp("lines released", 36'h0, 36'({line_out, line_oe}));
        repeat (2000) @(posedge clk);
        #2 cmp("valid after gap", 36'h0, 36'({vld_s, vld_a}));
        $display("test %s done", name);
    endtask
    always @(posedge clk) begin
        noise <= ~noise;
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            n_errors++;
            report_and_stop();
        end
    end
    // ==========================================================
    // main sequence
    initial begin
        repeat (3) @(posedge clk);
        #2 cmp("reset outputs", 36'h0,
               36'({vld_s, dat_s, ser_tx, line_oe, vld_a, dat_a}));
        rst = 1'b0;
        $display("test reset done");
        setup(-1, -1);
        run_seq("match", 1'b0, 1'b1, 1'b1);
        setup(-1, -1);
        run_seq("single word", 1'b1, 1'b0, 1'b0);
        setup(0, 8);
        run_seq("last digit miss", 1'b0, 1'b0, 1'b0);
        setup(4, -1);
        run_seq("fifth digit miss", 1'b0, 1'b0, 1'b1);
        report_and_stop();
    end
endmodule // remote_code_encoder_decoder_bench
